// File: logic/paged_id_register_bank.sv
// paged register bank: page select, identification fields, tool stamp,
// live and sticky status, device-ready location
// assumes the serial front end hands over one decoded access per cycle,
// synchronous to clk_in, and an nvm image that is stable once flagged valid
`default_nettype none

// Functional notes
// [RL1] register space is paged, 256 byte-wide locations per page
// [RL2] page select answers at offset one of every page
// [RL3] page select reads current page; a write switches pages at once
// [RL4] page zero offset 0xFE reports device ready
// [RL5] only pages 0,1,2,3,5 and 9 carry content
// [RL6] sticky bits stay set until host writes zero to them
// [RL7] self-clearing bits drop by themselves when the condition goes
// [RL8] silicon revision, read only, bits 3:0 at page zero offset zero
// [RL9] four-digit part number over two read-only bytes, nibble per digit
// [RL10] speed grade index: A=0, B=1, C=2, D=3, H=7
// [RL11] revision letter index from zero: A=0, B=1, C=2
// [RL12] tool stamp at 0x06..0x08 is read-write with major in bits 4:1
// [RL13] temperature grade at 0x09 and package code at 0x0A are readable
// [RL14] writable registers take their defaults from nvm at power-up; only page and tool stamp load from nvm, sticky resets to STICKY_RST
// [RL15] host reads and writes are accepted at any time after power-up
// [RL16] host leaves undescribed locations unwritten
// [RL17] full address is selected page over the access offset
// [RL18] writes to read-only identification registers are ignored
module paged_id_register_bank
	import id_bank_pkg::*;
(
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	// decoded host access from the serial front end
	input  wire host_access_t acc_in,
	// nvm image and load handshake
	input  wire nvm_image_t   nvm_in,
	input  wire logic         nvm_valid_in,
	// hardware status conditions
	input  wire logic [7:0]   status_in,
	// read answer
	output logic [7:0]        rdata_out,
	output logic              rvalid_out,
	// state seen by the rest of the device
	output logic [7:0]        page_out,
	output logic              page_valid_out,
	output logic              ready_out,
	output logic [3:0]        tool_major_out,
	output logic [2:0]        tool_id_out,
	output logic [7:0]        sticky_out
);

	//**************************************************************
	// decode helpers
	//**************************************************************

	// pages outside this list hold nothing but the page select
	function automatic logic page_has_content(input logic [7:0] pg);
		case (pg)
			PAGE_ALARM, PAGE_OUTPUT, PAGE_DIV_PR,
			PAGE_DIV_N, PAGE_LOOP, PAGE_CTRL_IO:
				page_has_content = 1'b1; // [RL5]
			default:
				page_has_content = 1'b0;
		endcase
	endfunction

	// page zero location hit for a given full address
	function automatic logic hit0(input logic [15:0] full,
		input logic [7:0] ofs);
		hit0 = (full == {PAGE_ALARM, ofs});
	endfunction

	//**************************************************************
	// reset release
	//**************************************************************

	logic rstn_meta;
	logic rstn_sync;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rstn_meta <= 1'b0;
			rstn_sync <= 1'b0;
		end else begin
			rstn_meta <= 1'b1;
			rstn_sync <= rstn_meta;
		end
	end

	//**************************************************************
	// state
	//**************************************************************

	boot_state_t state;
	logic [7:0]  page;
	logic [23:0] tool_stamp;
	logic [7:0]  live;
	logic [7:0]  sticky;

	//**************************************************************
	// address decode
	//**************************************************************

	wire logic [15:0] full_addr = {page, acc_in.offset}; // [RL17]
	wire logic        wr        = acc_in.wr;
	wire logic        rd        = acc_in.rd;

	// same register on every page, whatever the page holds
	wire logic hit_page   = (acc_in.offset == OFS_PAGE); // [RL2] [RL1]
	wire logic hit_sil    = hit0(full_addr, OFS_SILICON);
	wire logic hit_pn_lo  = hit0(full_addr, OFS_PN_LOW);
	wire logic hit_pn_hi  = hit0(full_addr, OFS_PN_HIGH);
	wire logic hit_speed  = hit0(full_addr, OFS_SPEED);
	wire logic hit_rev    = hit0(full_addr, OFS_REVISION);
	wire logic hit_tool0  = hit0(full_addr, OFS_TOOL_LOW);
	wire logic hit_tool1  = hit0(full_addr, OFS_TOOL_MID);
	wire logic hit_tool2  = hit0(full_addr, OFS_TOOL_HIGH);
	wire logic hit_therm  = hit0(full_addr, OFS_THERMAL);
	wire logic hit_house  = hit0(full_addr, OFS_HOUSING);
	wire logic hit_live   = hit0(full_addr, OFS_LIVE);
	wire logic hit_sticky = hit0(full_addr, OFS_STICKY);
	wire logic hit_ready  = hit0(full_addr, OFS_READY);

	// accesses are live from the third rising edge of clk_in after rstn_in rises, already in the load state
	wire logic loading  = (state == ST_LOAD);
	wire logic nvm_take = loading && nvm_valid_in;

	//**************************************************************
	// next values
	//**************************************************************

	// nvm load wins over a host write landing in the same cycle,
	// so the power-up image is never half overwritten
	wire logic [7:0] next_page =
		nvm_take ? nvm_in.page : // [RL14]
		(wr && hit_page) ? acc_in.wdata : // [RL3]
		page;

	// one write lane per tool stamp byte; read-only ids get no lane
	wire logic [2:0]  hit_tool = {hit_tool2, hit_tool1, hit_tool0};
	wire logic [23:0] next_tool;

	for (genvar b = 0; b < 3; b++) begin : g_tool_lane
		assign next_tool[8*b +: 8] =
			(!nvm_take && wr && hit_tool[b]) ? acc_in.wdata : // [RL18]
			tool_stamp[8*b +: 8]; // [RL12]
	end

	wire logic [23:0] next_tool_stamp =
		nvm_take ? nvm_in.tool_stamp : next_tool; // [RL14]

	// a zero written to a sticky bit clears it; ones are ignored
	wire logic [7:0] sticky_clr =
		(wr && hit_sticky) ? ~acc_in.wdata : 8'h00; // [RL6]

	wire logic [7:0] next_sticky;
	wire logic [7:0] next_live;

	// per status bit: a new event in the clearing cycle survives the
	// clear; the live copy follows the condition, so it drops unasked
	for (genvar i = 0; i < 8; i++) begin : g_status_bit
		assign next_sticky[i] = STATUS_MASK[i] &&
			((sticky[i] && !sticky_clr[i]) || status_in[i]); // [RL6]
		assign next_live[i] = STATUS_MASK[i] && status_in[i]; // [RL7]
	end

	wire boot_state_t next_state = nvm_take ? ST_RUN : state;

	//**************************************************************
	// read mux
	//**************************************************************

	wire logic [7:0] ready_code = loading ? READY_NO : READY_YES;

	wire logic [7:0] next_rdata =
		hit_page   ? page : // [RL3]
		hit_sil    ? {4'h0, SILICON_REV} : // [RL8]
		hit_pn_lo  ? PART_DIGITS[7:0] : // [RL9]
		hit_pn_hi  ? PART_DIGITS[15:8] : // [RL9]
		hit_speed  ? SPEED_CODE : // [RL10]
		hit_rev    ? REV_CODE : // [RL11]
		hit_tool0  ? tool_stamp[7:0] : // [RL12]
		hit_tool1  ? tool_stamp[15:8] :
		hit_tool2  ? tool_stamp[23:16] :
		hit_therm  ? THERMAL_IND : // [RL13]
		hit_house  ? HOUSING_QFN44 : // [RL13]
		hit_live   ? live :
		hit_sticky ? sticky :
		hit_ready  ? ready_code : // [RL4]
		READ_NONE;

	//**************************************************************
	// registers
	//**************************************************************

	always_ff @(posedge clk_in or negedge rstn_sync) begin
		if (!rstn_sync) begin
			state      <= ST_LOAD;
			page       <= PAGE_RST;
			tool_stamp <= TOOL_RST;
			live       <= STICKY_RST;
			sticky     <= STICKY_RST;
		end else begin
			state      <= next_state;
			page       <= next_page;
			tool_stamp <= next_tool_stamp;
			live       <= next_live;
			sticky     <= next_sticky;
		end
	end

	// read answer one cycle after the request, accepted in any state
	always_ff @(posedge clk_in or negedge rstn_sync) begin
		if (!rstn_sync) begin
			rdata_out  <= READ_NONE;
			rvalid_out <= 1'b0;
		end else begin
			rdata_out  <= rd ? next_rdata : READ_NONE; // [RL15]
			rvalid_out <= rd; // [RL15]
		end
	end

	// side copies kept in step with the registers they mirror
	always_ff @(posedge clk_in or negedge rstn_sync) begin
		if (!rstn_sync) begin
			page_out       <= PAGE_RST;
			page_valid_out <= 1'b1;
			ready_out      <= 1'b0;
			tool_major_out <= TOOL_RST[TOOL_MAJOR_LSB +: 4];
			tool_id_out    <= TOOL_RST[TOOL_ID_LSB +: 3];
			sticky_out     <= STICKY_RST;
		end else begin
			page_out       <= next_page;
			page_valid_out <= page_has_content(next_page); // [RL5]
			ready_out      <= (next_state == ST_RUN); // [RL4]
			tool_major_out <=
				next_tool_stamp[16 + TOOL_MAJOR_LSB +: 4]; // [RL12]
			tool_id_out    <= next_tool_stamp[16 + TOOL_ID_LSB +: 3];
			sticky_out     <= next_sticky;
		end
	end

endmodule // paged_id_register_bank

`default_nettype wire

// File: logic/id_bank_pkg.sv
// constants, field layout and carrier types for the paged id register bank
// assumes one 40 MHz clock domain shared with the serial front end
`default_nettype none

package id_bank_pkg;

	// page geometry
	localparam int         PAGE_SPAN      = 256;
	localparam logic [7:0] PAGE_RST       = 8'h00;
	localparam logic [7:0] PAGE_ALARM     = 8'h00;
	localparam logic [7:0] PAGE_OUTPUT    = 8'h01;
	localparam logic [7:0] PAGE_DIV_PR    = 8'h02;
	localparam logic [7:0] PAGE_DIV_N     = 8'h03;
	localparam logic [7:0] PAGE_LOOP      = 8'h05;
	localparam logic [7:0] PAGE_CTRL_IO   = 8'h09;

	// offsets within a page
	localparam logic [7:0] OFS_SILICON    = 8'h00;
	localparam logic [7:0] OFS_PAGE       = 8'h01;
	localparam logic [7:0] OFS_PN_LOW     = 8'h02;
	localparam logic [7:0] OFS_PN_HIGH    = 8'h03;
	localparam logic [7:0] OFS_SPEED      = 8'h04;
	localparam logic [7:0] OFS_REVISION   = 8'h05;
	localparam logic [7:0] OFS_TOOL_LOW   = 8'h06;
	localparam logic [7:0] OFS_TOOL_MID   = 8'h07;
	localparam logic [7:0] OFS_TOOL_HIGH  = 8'h08;
	localparam logic [7:0] OFS_THERMAL    = 8'h09;
	localparam logic [7:0] OFS_HOUSING    = 8'h0A;
	localparam logic [7:0] OFS_LIVE       = 8'h0C;
	localparam logic [7:0] OFS_STICKY     = 8'h11;
	localparam logic [7:0] OFS_READY      = 8'hFE;

	// tool stamp fields in the high byte
	localparam int         TOOL_MAJOR_LSB = 1;
	localparam int         TOOL_ID_LSB    = 5;

	// identity values, all arbitrary
	localparam logic [3:0] SILICON_REV    = 4'h1;
	localparam logic [15:0] PART_DIGITS   = 16'h1234;

	// letter indices, temperature grade and package code
	localparam logic [7:0] GRADE_A        = 8'h00;
	localparam logic [7:0] GRADE_B        = 8'h01;
	localparam logic [7:0] GRADE_C        = 8'h02;
	localparam logic [7:0] GRADE_D        = 8'h03;
	localparam logic [7:0] GRADE_H        = 8'h07;
	localparam logic [7:0] SPEED_CODE     = GRADE_H;
	localparam logic [7:0] REV_A          = 8'h00;
	localparam logic [7:0] REV_B          = 8'h01;
	localparam logic [7:0] REV_C          = 8'h02;
	localparam logic [7:0] REV_CODE       = REV_C;
	localparam logic [7:0] THERMAL_IND    = 8'h00;
	localparam logic [7:0] HOUSING_QFN44  = 8'h01;

	// status layout and reset values
	localparam logic [7:0] STATUS_MASK    = 8'h23;
	localparam logic [7:0] STICKY_RST     = 8'h00;
	localparam logic [23:0] TOOL_RST      = 24'h000000;
	localparam logic [7:0] READY_YES      = 8'h01;
	localparam logic [7:0] READY_NO       = 8'h00;
	localparam logic [7:0] READ_NONE      = 8'h00;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] offset;
		logic [7:0] wdata;
	} host_access_t;

	typedef struct packed {
		logic [7:0]  page;
		logic [23:0] tool_stamp;
	} nvm_image_t;

	typedef enum logic {
		ST_LOAD = 1'b0,
		ST_RUN  = 1'b1
	} boot_state_t;

endpackage

`default_nettype wire

// File: verif/id_bank_asserts.sv
// port checks for the paged id register bank
// assumes one clock domain and the bind at the foot
`default_nettype none
// ****************
// checker
// ****************
module id_bank_asserts
	import id_bank_pkg::*;
(
	// clock and reset
	input wire logic         clk_in,
	input wire logic         rstn_in,
	// watched ports
	input wire host_access_t acc_in,
	input wire logic [7:0]   rdata_out,
	input wire logic         rvalid_out,
	input wire logic [7:0]   page_out,
	input wire logic         page_valid_out,
	input wire logic         ready_out,
	input wire logic [3:0]   tool_major_out,
	input wire logic [7:0]   sticky_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	wire p0  = page_out == PAGE_ALARM;
	wire rd  = acc_in.rd;
	wire ofs_w = acc_in.wr && ready_out;
	AST_READ_ANSWER: assert property (rd |=> rvalid_out)
		else $error("read not answered");
	AST_IDLE_QUIET: assert property (!rd |=> !rvalid_out
		&& rdata_out == READ_NONE) else $error("spurious answer");
	AST_PAGE_WRITE: assert property (ofs_w
		&& acc_in.offset == OFS_PAGE
		|=> page_out == $past(acc_in.wdata))
		else $error("page not switched");
	AST_PAGE_READ: assert property (rd
		&& acc_in.offset == OFS_PAGE
		|=> rdata_out == $past(page_out))
		else $error("page read wrong");
	AST_PAGE_VALID: assert property (page_valid_out ==
		(page_out inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h09}))
		else $error("page content flag wrong");
	AST_READY_STAYS: assert property (ready_out |=> ready_out)
		else $error("ready dropped");
	AST_READY_READ: assert property (rd && p0
		&& acc_in.offset == OFS_READY
		|=> rdata_out == ($past(ready_out) ? READY_YES : READY_NO))
		else $error("ready read wrong");
	AST_SILICON: assert property (rd && p0
		&& acc_in.offset == OFS_SILICON
		|=> rdata_out == {4'h0, SILICON_REV})
		else $error("silicon revision wrong");
	AST_STICKY_HOLDS: assert property (!(acc_in.wr
		&& acc_in.offset == OFS_STICKY) |=> (sticky_out
		& $past(sticky_out)) == $past(sticky_out))
		else $error("sticky bit lost");
	AST_TOOL_MAJOR: assert property (ofs_w && p0
		&& acc_in.offset == OFS_TOOL_HIGH
		|=> tool_major_out == $past(acc_in.wdata[4:1]))
		else $error("tool major wrong");
	cover property (ofs_w && acc_in.offset == OFS_PAGE);
	cover property (acc_in.wr && acc_in.offset == OFS_STICKY);
	cover property (rd && p0 && acc_in.offset == OFS_READY);
endmodule // id_bank_asserts

bind paged_id_register_bank id_bank_asserts chk (.*);
`default_nettype wire

// File: verif/host_model.sv
// host side: one decoded access per call, then a quiet cycle
// assumes the bench calls op from one thread only
`default_nettype none
module host_model
	import id_bank_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output var host_access_t acc_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial acc_out = '0;
	// idle offset and data are inverted so stale values never pass
	// writes only go to described places
	task automatic op(input logic w, input logic [7:0] o, d,
		output logic [7:0] q);
		@(negedge clk_in);
		acc_out <= '{rd: !w, wr: w, offset: o, wdata: d};
		@(negedge clk_in);
		acc_out <= '{rd: 1'b0, wr: 1'b0, offset: ~o, wdata: ~d};
		q = rvalid_in ? rdata_in : 8'hXX;
	endtask
endmodule // host_model
`default_nettype wire

// File: verif/paged_id_register_bank_bench.sv
// self-checking bench for the paged id register bank
// assumes host_model makes every access
`default_nettype none
module paged_id_register_bank_bench import id_bank_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] NVM_TOOL = 24'h9C5A3E;
	logic         clk_in = 1'b0;
	logic         rstn_in = 1'b0;
	logic         nvm_valid_in = 1'b0;
	logic [7:0]   status_in = 8'h00;
	logic [7:0]   rdata_out, page_out, sticky_out, q;
	logic         rvalid_out, page_valid_out, ready_out;
	logic [3:0]   tool_major_out;
	logic [2:0]   tool_id_out;
	host_access_t acc_in;
	nvm_image_t   nvm_in = '{page: PAGE_RST, tool_stamp: NVM_TOOL};
	int           errors = 0;
	int           checks_done = 0;
	logic [15:0]  rows [10] = '{{OFS_SILICON, 4'h0, SILICON_REV},
		{OFS_PN_LOW, PART_DIGITS[7:0]}, {OFS_PN_HIGH, PART_DIGITS[15:8]},
		{OFS_SPEED, GRADE_H}, {OFS_REVISION, REV_C},
		{OFS_THERMAL, THERMAL_IND}, {OFS_HOUSING, HOUSING_QFN44},
		{OFS_READY, READY_YES}, {OFS_TOOL_LOW, NVM_TOOL[7:0]},
		{8'h0B, READ_NONE}};
	paged_id_register_bank dut (.clk_in, .rstn_in, .acc_in, .nvm_in,
		.nvm_valid_in, .status_in, .rdata_out, .rvalid_out, .page_out,
		.page_valid_out, .ready_out, .tool_major_out, .tool_id_out,
		.sticky_out);
	host_model host (.clk_in, .rdata_in(rdata_out),
		.rvalid_in(rvalid_out), .acc_out(acc_in));
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] o, e);
		host.op(1'b0, o, 8'h00, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] o, d);
		host.op(1'b1, o, d, q);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#20us;
		errors++;
		$display("ERROR %0t: watchdog", $time);
		end_sim;
	end
	initial begin
		repeat (3) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		chk({7'h0, ready_out}, 8'h00);
		rd(OFS_READY, READY_NO);
		nvm_valid_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk({7'h0, ready_out}, 8'h01);
		foreach (rows[i]) begin
			rd(rows[i][15:8], rows[i][7:0]);
		end
		rd(OFS_TOOL_HIGH, NVM_TOOL[23:16]);
		wr(OFS_TOOL_HIGH, 8'hB7);
		chk({4'h0, tool_major_out}, 8'h0B);
		chk({5'h0, tool_id_out}, 8'h05);
		rd(OFS_TOOL_HIGH, 8'hB7);
		wr(OFS_PN_LOW, 8'hFF);
		rd(OFS_PN_LOW, PART_DIGITS[7:0]);
		for (int p = 0; p < 11; p++) begin
			wr(OFS_PAGE, 8'(p));
			rd(OFS_PAGE, 8'(p));
			chk({7'h0, page_valid_out}, {7'h0, 8'(p) inside
				{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h09}});
		end
		rd(OFS_READY, READ_NONE);
		wr(OFS_PAGE, PAGE_ALARM);
		status_in = 8'hFF;
		@(negedge clk_in);
		status_in = 8'h00;
		repeat (2) @(negedge clk_in);
		rd(OFS_LIVE, READ_NONE);
		rd(OFS_STICKY, STATUS_MASK);
		wr(OFS_STICKY, 8'h22);
		chk(sticky_out, 8'h22);
		status_in = 8'h01;
		rd(OFS_LIVE, 8'h01);
		wr(OFS_STICKY, 8'h00);
		chk(sticky_out, 8'h01);
		status_in = 8'h00;
		wr(OFS_STICKY, 8'h00);
		chk(sticky_out, 8'h00);
		rd(OFS_LIVE, READ_NONE);
		// mid-run reset: nvm image reloads, host changes are lost
		nvm_in.page = PAGE_LOOP;
		rstn_in = 1'b0;
		@(negedge clk_in);
		chk({4'h0, tool_major_out}, 8'h00);
		chk({7'h0, ready_out}, 8'h00);
		rstn_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk({7'h0, ready_out}, 8'h00);
		@(negedge clk_in);
		chk({7'h0, ready_out}, 8'h01);
		chk(page_out, PAGE_LOOP);
		rd(OFS_PAGE, PAGE_LOOP);
		rd(OFS_SILICON, READ_NONE);
		wr(OFS_PAGE, PAGE_ALARM);
		rd(OFS_TOOL_HIGH, NVM_TOOL[23:16]);
		end_sim;
	end
endmodule // paged_id_register_bank_bench
`default_nettype wire
